// File: core/cps_pkg.sv
// Operation
// - mode pins are captured and held on the rising edge of init ready.
// - init ready is an open-drain two-way pin showing readiness to configure.
// - program request low starts configuration; outside parties pull it low.
// - done is an open-drain two-way pin showing configuration end and startup.
// - pad a receives and pad b sends in slave mode; reversed in master.
// - in master mode a low-active select output picks the boot flash.
// - io tristate control held low puts every user pin in high impedance.
// - test data out shifts scan and configuration data under the test port.
// - the first chosen configuration port is locked until power-up.
package cps_pkg;
    // filtered pin vector layout
    localparam int PIN_W     = 11;
    localparam int PIN_MODE  = 0;
    localparam int PIN_PAD_B = 2;
    localparam int PIN_TOE   = 3;
    localparam int PIN_TDI   = 4;
    localparam int PIN_TMS   = 5;
    localparam int PIN_TCK   = 6;
    localparam int PIN_DONE  = 7;
    localparam int PIN_INIT  = 8;
    localparam int PIN_PROG  = 9;
    localparam int PIN_SS    = 10;
    // pull-ups idle high, test clock idles low
    localparam logic [PIN_W-1:0] PIN_RESET = 11'h7bf;

    // configuration mode pins and port lock codes
    localparam int              MODE_W      = 2;
    localparam logic [MODE_W-1:0] MODE_MASTER = 2'h0;
    localparam logic [MODE_W-1:0] MODE_SLAVE  = 2'h1;
    localparam logic [MODE_W-1:0] MODE_TAP    = 2'h3;
    localparam int              LOCK_W      = 2;
    localparam logic [LOCK_W-1:0] LOCK_NONE   = 2'h0;
    localparam logic [LOCK_W-1:0] LOCK_MASTER = 2'h1;
    localparam logic [LOCK_W-1:0] LOCK_SLAVE  = 2'h2;
    localparam logic [LOCK_W-1:0] LOCK_TAP    = 2'h3;

    // configuration word and flash read header
    localparam int          WORD_W         = 32;
    localparam int          CNT_W          = 5;
    localparam int          HDR_W          = 32;
    localparam logic [7:0]  FLASH_READ_CMD = 8'h03;
    localparam logic [23:0] FLASH_ADDR     = 24'h00_0000;
    localparam int          MASTER_BITS    = HDR_W + WORD_W;
    localparam int          BIT_W          = 7;

    // timing
    localparam int CLK_NS        = 25;
    localparam int CLEAR_NS      = 400;
    localparam int CLEAR_CYC     = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
    localparam int CLR_W         = 5;
    localparam int SCLK_HALF_NS  = 200;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int DIV_W         = 4;

    // test port instructions
    localparam int              IR_W       = 4;
    localparam logic [IR_W-1:0] IR_BYPASS  = 4'hf;
    localparam logic [IR_W-1:0] IR_CFG     = 4'h2;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h5;

    typedef enum logic [6:0] {
        ST_CLEAR     = 7'h01,
        ST_INIT_WAIT = 7'h02,
        ST_MASTER    = 7'h04,
        ST_SLAVE     = 7'h08,
        ST_TAP       = 7'h10,
        ST_WAKE      = 7'h20,
        ST_USER      = 7'h40
    } cps_cfg_st_t;

    typedef enum logic [15:0] {
        T_RESET = 16'h0001, T_IDLE  = 16'h0002, T_SELDR = 16'h0004,
        T_CAPDR = 16'h0008, T_SHDR  = 16'h0010, T_EX1DR = 16'h0020,
        T_PADR  = 16'h0040, T_EX2DR = 16'h0080, T_UPDR  = 16'h0100,
        T_SELIR = 16'h0200, T_CAPIR = 16'h0400, T_SHIR  = 16'h0800,
        T_EX1IR = 16'h1000, T_PAIR  = 16'h2000, T_EX2IR = 16'h4000,
        T_UPIR  = 16'h8000
    } cps_tap_st_t;

    // configuration port asked for by the mode pins
    function automatic logic [LOCK_W-1:0] cps_port_of(
        input logic [MODE_W-1:0] mode);
        if (mode == MODE_MASTER)
            return LOCK_MASTER;
        else if (mode == MODE_SLAVE)
            return LOCK_SLAVE;
        else
            return LOCK_TAP;
    endfunction
endpackage

// File: core/cps_slave_link.sv
`timescale 1ns/100ps
module cps_slave_link (
    input  wire logic                      sclk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      select_n_i,
    input  wire logic                      data_i,
    output logic                           data_o,
    output logic [cps_pkg::WORD_W-1:0]     word_o,
    output logic                           word_tgl_o
);
    import cps_pkg::*;

    logic              frame_rst;
    logic [WORD_W-1:0] sr_reg;
    logic [CNT_W-1:0]  cnt_reg;
    logic              last_bit;

    // host clock stops between frames, so select high ends the frame
    assign frame_rst = !rst_n_i || select_n_i;
    assign last_bit  = (cnt_reg == CNT_W'(WORD_W - 1));

    // pad a is the receive side in slave mode
    always_ff @(posedge sclk_i or posedge frame_rst) begin
        if (frame_rst) begin
            sr_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            sr_reg  <= {sr_reg[WORD_W-2:0], data_i};
            cnt_reg <= last_bit ? '0 : cnt_reg + 1'b1;
        end
    end

    // word and toggle survive the frame end so the system side can take them
    always_ff @(posedge sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_o     <= '0;
            word_tgl_o <= 1'b0;
        end else if (!select_n_i && last_bit) begin
            word_o     <= {sr_reg[WORD_W-2:0], data_i};
            word_tgl_o <= !word_tgl_o;
        end
    end

    // pad b echoes the oldest shifted bit so the host can check wiring
    always_ff @(negedge sclk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            data_o <= 1'b0;
        else
            data_o <= sr_reg[WORD_W-1];
    end

    a_link_count: assert property (@(posedge sclk_i) disable iff (frame_rst)
        last_bit |=> cnt_reg == '0)
        else $error("slave link bit count did not wrap");
endmodule // cps_slave_link

// File: core/cps_top.sv
`timescale 1ns/100ps
module cps_top (
    input  wire logic                       SYS_CLK_I,
    input  wire logic                       RESETN_I,
    input  wire logic [cps_pkg::MODE_W-1:0] CFG_MODE_I,
    input  wire logic                       INIT_READY_N_I,
    output logic                            INIT_READY_N_O,
    output logic                            INIT_READY_N_OE_O,
    input  wire logic                       PROGRAM_REQUEST_N_I,
    input  wire logic                       DONE_I,
    output logic                            DONE_O,
    output logic                            DONE_OE_O,
    input  wire logic                       CONFIG_SERIAL_CLOCK_I,
    output logic                            CONFIG_SERIAL_CLOCK_O,
    output logic                            CONFIG_SERIAL_CLOCK_OE_O,
    input  wire logic                       SERIAL_DATA_PAD_A_I,
    output logic                            SERIAL_DATA_PAD_A_O,
    output logic                            SERIAL_DATA_PAD_A_OE_O,
    input  wire logic                       SERIAL_DATA_PAD_B_I,
    output logic                            SERIAL_DATA_PAD_B_O,
    output logic                            SERIAL_DATA_PAD_B_OE_O,
    output logic                            FLASH_SELECT_N_O,
    input  wire logic                       SLAVE_SELECT_IN_N_I,
    input  wire logic                       IO_TRISTATE_CTRL_N_I,
    output logic                            USER_IO_HIZ_O,
    input  wire logic                       TCK_I,
    input  wire logic                       TMS_I,
    input  wire logic                       TDI_I,
    output logic                            TDO_O,
    output logic                            TDO_OE_O,
    output logic [cps_pkg::WORD_W-1:0]      CONFIG_WORD_O,
    output logic                            USER_MODE_O,
    output logic                            PORT_REJECT_O
);
    import cps_pkg::*;

    // pins from outside pass three flops; a change counts when two agree
    logic [PIN_W-1:0]  pin_raw;
    logic [PIN_W-1:0]  pin_s1_reg;
    logic [PIN_W-1:0]  pin_s2_reg;
    logic [PIN_W-1:0]  pin_s3_reg;
    logic [PIN_W-1:0]  pin_reg;
    logic [PIN_W-1:0]  pin_q_reg;
    logic [PIN_W-1:0]  pin_next;
    logic              prog_n;
    logic              init_rise;
    logic              done_hi;
    logic              tck_rise;
    logic              tck_fall;
    logic              ss_n;
    logic [MODE_W-1:0] mode_pin;

    assign pin_raw = {SLAVE_SELECT_IN_N_I, PROGRAM_REQUEST_N_I,
                      INIT_READY_N_I, DONE_I, TCK_I, TMS_I, TDI_I,
                      IO_TRISTATE_CTRL_N_I, SERIAL_DATA_PAD_B_I, CFG_MODE_I};
    assign pin_next = (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg))
                    | (pin_reg & (pin_s2_reg ^ pin_s3_reg));

    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            pin_s1_reg <= PIN_RESET;
            pin_s2_reg <= PIN_RESET;
            pin_s3_reg <= PIN_RESET;
            pin_reg    <= PIN_RESET;
            pin_q_reg  <= PIN_RESET;
        end else begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_reg    <= pin_next;
            pin_q_reg  <= pin_reg;
        end
    end

    // named views of the filtered pins
    assign prog_n    = pin_reg[PIN_PROG];
    assign init_rise = pin_reg[PIN_INIT] && !pin_q_reg[PIN_INIT];
    assign done_hi   = pin_reg[PIN_DONE];
    assign tck_rise  = pin_reg[PIN_TCK] && !pin_q_reg[PIN_TCK];
    assign tck_fall  = !pin_reg[PIN_TCK] && pin_q_reg[PIN_TCK];
    assign ss_n      = pin_reg[PIN_SS];
    assign mode_pin  = pin_reg[PIN_MODE +: MODE_W];

    // configuration sequencer state
    cps_cfg_st_t       st_reg;
    cps_cfg_st_t       st_next;
    cps_cfg_st_t       port_state;
    logic [MODE_W-1:0] mode_reg;
    logic [MODE_W-1:0] mode_next;
    logic [LOCK_W-1:0] lock_reg;
    logic [LOCK_W-1:0] lock_next;
    logic [LOCK_W-1:0] req_port;
    logic              port_ok;
    logic              pick;
    logic              reject_next;
    logic [CLR_W-1:0]  clr_reg;
    logic [CLR_W-1:0]  clr_next;
    logic [WORD_W-1:0] word_next;
    logic              m_done;
    logic              slave_take;
    logic              tap_take;

    // a locked port refuses any other until power-up reset
    assign req_port   = cps_port_of(mode_pin);
    assign port_ok    = (lock_reg == LOCK_NONE) || (lock_reg == req_port);
    assign pick       = (st_reg == ST_INIT_WAIT) && init_rise;
    assign port_state = (req_port == LOCK_MASTER) ? ST_MASTER :
                        (req_port == LOCK_SLAVE) ? ST_SLAVE : ST_TAP;
    assign mode_next  = pick ? mode_pin : mode_reg;
    assign lock_next  = (pick && port_ok) ? req_port : lock_reg;
    assign reject_next = (pick && !port_ok) ||
                         (PORT_REJECT_O && st_reg != ST_CLEAR);
    assign clr_next   = (st_reg != ST_CLEAR || !prog_n) ? CLR_W'(CLEAR_CYC) :
                        (clr_reg == '0) ? clr_reg : clr_reg - 1'b1;

    always_comb begin
        st_next = st_reg;
        if (!prog_n) begin
            st_next = ST_CLEAR;
        end else begin
            case (st_reg)
                ST_CLEAR:     if (clr_reg == '0) st_next = ST_INIT_WAIT;
                ST_INIT_WAIT: if (pick && port_ok) st_next = port_state;
                ST_MASTER:    if (m_done) st_next = ST_WAKE;
                ST_SLAVE:     if (slave_take) st_next = ST_WAKE;
                ST_TAP:       if (tap_take) st_next = ST_WAKE;
                ST_WAKE:      if (done_hi) st_next = ST_USER;
                ST_USER:      st_next = ST_USER;
                default:      st_next = ST_CLEAR;
            endcase
        end
    end

    // lock is cleared by power-up reset only, never by a program request
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            st_reg        <= ST_CLEAR;
            mode_reg      <= MODE_TAP;
            lock_reg      <= LOCK_NONE;
            PORT_REJECT_O <= 1'b0;
            clr_reg       <= CLR_W'(CLEAR_CYC);
            CONFIG_WORD_O <= '0;
        end else begin
            st_reg        <= st_next;
            mode_reg      <= mode_next;
            lock_reg      <= lock_next;
            PORT_REJECT_O <= reject_next;
            clr_reg       <= clr_next;
            CONFIG_WORD_O <= word_next;
        end
    end

    // master flash read: divided clock, command out on a, data in on b
    logic [DIV_W-1:0]  div_reg;
    logic              sclk_reg;
    logic [BIT_W-1:0]  bit_reg;
    logic [HDR_W-1:0]  tx_reg;
    logic [WORD_W-1:0] rx_reg;
    logic [WORD_W-1:0] rx_shift;
    logic              m_act;
    logic              m_load;
    logic              div_wrap;
    logic              m_fall;

    assign m_act    = (st_reg == ST_MASTER);
    assign m_load   = (st_reg != ST_MASTER) && (st_next == ST_MASTER);
    assign div_wrap = (div_reg == DIV_W'(SCLK_HALF_CYC - 1));
    assign m_fall   = m_act && div_wrap && sclk_reg;
    assign m_done   = m_fall && (bit_reg == BIT_W'(MASTER_BITS - 1));
    // sampled at the fall: the filtered pin shows mid-high-phase data
    assign rx_shift = {rx_reg[WORD_W-2:0], pin_reg[PIN_PAD_B]};

    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            div_reg  <= '0;
            sclk_reg <= 1'b0;
            bit_reg  <= '0;
            tx_reg   <= '0;
            rx_reg   <= '0;
        end else if (!m_act || m_load) begin
            div_reg  <= '0;
            sclk_reg <= 1'b0;
            bit_reg  <= '0;
            tx_reg   <= {FLASH_READ_CMD, FLASH_ADDR};
        end else begin
            div_reg  <= div_wrap ? '0 : div_reg + 1'b1;
            sclk_reg <= div_wrap ? !sclk_reg : sclk_reg;
            if (m_fall) begin
                bit_reg <= bit_reg + 1'b1;
                tx_reg  <= {tx_reg[HDR_W-2:0], 1'b0};
                rx_reg  <= (bit_reg >= BIT_W'(HDR_W)) ? rx_shift : rx_reg;
            end
        end
    end

    // slave words arrive on the host clock; toggle crosses, word is stable
    logic [WORD_W-1:0] lw_word;
    logic              lw_tgl;
    logic              tgl_s1_reg;
    logic              tgl_s2_reg;
    logic              tgl_s3_reg;

    cps_slave_link u_link (
        .sclk_i     (CONFIG_SERIAL_CLOCK_I),
        .rst_n_i    (RESETN_I),
        .select_n_i (SLAVE_SELECT_IN_N_I),
        .data_i     (SERIAL_DATA_PAD_A_I),
        .data_o     (SERIAL_DATA_PAD_B_O),
        .word_o     (lw_word),
        .word_tgl_o (lw_tgl)
    );

    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            tgl_s1_reg <= 1'b0;
            tgl_s2_reg <= 1'b0;
            tgl_s3_reg <= 1'b0;
        end else begin
            tgl_s1_reg <= lw_tgl;
            tgl_s2_reg <= tgl_s1_reg;
            tgl_s3_reg <= tgl_s2_reg;
        end
    end

    assign slave_take = (st_reg == ST_SLAVE) && (tgl_s2_reg ^ tgl_s3_reg);

    // test access port, stepped on filtered test clock edges
    cps_tap_st_t     tap_reg;
    cps_tap_st_t     tap_next;
    logic [IR_W-1:0] ir_reg;
    logic [IR_W-1:0] ir_sr_reg;
    logic [WORD_W-1:0] dr_reg;
    logic            byp_reg;
    logic            tms;
    logic            tdi;

    assign tms      = pin_reg[PIN_TMS];
    assign tdi      = pin_reg[PIN_TDI];
    assign tap_take = (st_reg == ST_TAP) && tck_rise && (tap_reg == T_UPDR)
                      && (ir_reg == IR_CFG);
    assign word_next = m_done ? rx_shift :
                       slave_take ? lw_word :
                       tap_take ? dr_reg : CONFIG_WORD_O;

    always_comb begin
        case (tap_reg)
            T_RESET: tap_next = tms ? T_RESET : T_IDLE;
            T_IDLE:  tap_next = tms ? T_SELDR : T_IDLE;
            T_SELDR: tap_next = tms ? T_SELIR : T_CAPDR;
            T_CAPDR: tap_next = tms ? T_EX1DR : T_SHDR;
            T_SHDR:  tap_next = tms ? T_EX1DR : T_SHDR;
            T_EX1DR: tap_next = tms ? T_UPDR : T_PADR;
            T_PADR:  tap_next = tms ? T_EX2DR : T_PADR;
            T_EX2DR: tap_next = tms ? T_UPDR : T_SHDR;
            T_UPDR:  tap_next = tms ? T_SELDR : T_IDLE;
            T_SELIR: tap_next = tms ? T_RESET : T_CAPIR;
            T_CAPIR: tap_next = tms ? T_EX1IR : T_SHIR;
            T_SHIR:  tap_next = tms ? T_EX1IR : T_SHIR;
            T_EX1IR: tap_next = tms ? T_UPIR : T_PAIR;
            T_PAIR:  tap_next = tms ? T_EX2IR : T_PAIR;
            T_EX2IR: tap_next = tms ? T_UPIR : T_SHIR;
            T_UPIR:  tap_next = tms ? T_SELDR : T_IDLE;
            default: tap_next = T_RESET;
        endcase
    end

    // capture and shift act on the rising test clock edge
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            tap_reg   <= T_RESET;
            ir_reg    <= IR_BYPASS;
            ir_sr_reg <= '0;
            dr_reg    <= '0;
            byp_reg   <= 1'b0;
        end else if (tck_rise) begin
            tap_reg <= tap_next;
            case (tap_reg)
                T_RESET: ir_reg    <= IR_BYPASS;
                T_CAPIR: ir_sr_reg <= IR_CAPTURE;
                T_SHIR:  ir_sr_reg <= {tdi, ir_sr_reg[IR_W-1:1]};
                T_UPIR:  ir_reg    <= ir_sr_reg;
                T_CAPDR: dr_reg    <= CONFIG_WORD_O;
                T_SHDR: begin
                    dr_reg  <= {tdi, dr_reg[WORD_W-1:1]};
                    byp_reg <= tdi;
                end
                default: byp_reg <= byp_reg;
            endcase
        end
    end

    // test data out changes on the falling edge, driven only while shifting
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            TDO_O    <= 1'b0;
            TDO_OE_O <= 1'b0;
        end else if (tck_fall) begin
            TDO_O    <= (tap_reg == T_SHIR) ? ir_sr_reg[0] :
                        (ir_reg == IR_CFG) ? dr_reg[0] : byp_reg;
            TDO_OE_O <= (tap_reg == T_SHIR) || (tap_reg == T_SHDR);
        end
    end

    // pin drivers; open-drain pins only ever pull low
    assign INIT_READY_N_O = 1'b0;
    assign DONE_O         = 1'b0;
    assign SERIAL_DATA_PAD_A_O   = tx_reg[HDR_W-1];
    assign CONFIG_SERIAL_CLOCK_O = sclk_reg;

    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            INIT_READY_N_OE_O        <= 1'b1;
            DONE_OE_O                <= 1'b1;
            CONFIG_SERIAL_CLOCK_OE_O <= 1'b0;
            SERIAL_DATA_PAD_A_OE_O   <= 1'b0;
            SERIAL_DATA_PAD_B_OE_O   <= 1'b0;
            FLASH_SELECT_N_O         <= 1'b1;
            USER_IO_HIZ_O            <= 1'b0;
            USER_MODE_O              <= 1'b0;
        end else begin
            INIT_READY_N_OE_O        <= (st_next == ST_CLEAR);
            DONE_OE_O                <= !(st_next == ST_WAKE ||
                                          st_next == ST_USER);
            CONFIG_SERIAL_CLOCK_OE_O <= (st_next == ST_MASTER);
            SERIAL_DATA_PAD_A_OE_O   <= (st_next == ST_MASTER);
            SERIAL_DATA_PAD_B_OE_O   <= (st_next == ST_SLAVE) && !ss_n;
            FLASH_SELECT_N_O         <= (st_next != ST_MASTER);
            USER_IO_HIZ_O            <= !pin_reg[PIN_TOE];
            USER_MODE_O              <= (st_next == ST_USER);
        end
    end

    default clocking dc @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESETN_I);

    a_mode_latch: assert property (
        pick |=> mode_reg == $past(mode_pin) ##1 mode_reg == $past(mode_reg))
        else $error("mode not held after init ready rise");
    a_init_drive: assert property (
        (st_reg == ST_CLEAR) == INIT_READY_N_OE_O)
        else $error("init ready drive does not follow clear state");
    a_prog_clear: assert property (
        !prog_n |=> st_reg == ST_CLEAR && INIT_READY_N_OE_O)
        else $error("program request did not restart configuration");
    a_done_release: assert property (
        DONE_OE_O == !(st_reg == ST_WAKE || st_reg == ST_USER))
        else $error("done drive wrong for state");
    a_pad_dir: assert property (
        SERIAL_DATA_PAD_A_OE_O |-> !SERIAL_DATA_PAD_B_OE_O && m_act)
        else $error("both serial pads driven or pad a outside master");
    a_flash_sel: assert property (
        (st_reg == ST_MASTER) == !FLASH_SELECT_N_O)
        else $error("flash select wrong for master load");
    a_hiz: assert property (
        !pin_reg[PIN_TOE] |=> USER_IO_HIZ_O)
        else $error("user pins not released on tristate control");
    a_tdo_shift: assert property (
        tck_fall && tap_reg == T_SHDR |=> TDO_OE_O)
        else $error("test data out not driven in shift");
    a_port_lock: assert property (
        lock_reg != LOCK_NONE |=> lock_reg == $past(lock_reg))
        else $error("locked configuration port changed");
    a_sclk_drive: assert property (
        CONFIG_SERIAL_CLOCK_OE_O == (st_reg == ST_MASTER))
        else $error("config clock drive wrong for mode");
endmodule // cps_top

// File: bench/cps_flash_model.sv
`timescale 1ns/100ps
module cps_flash_model #(
    parameter logic [31:0] WORD = 32'ha5c3_0f96
) (
    input  wire logic        sclk_i,
    input  wire logic        select_n_i,
    input  wire logic        data_i,
    output logic             data_o,
    output logic [31:0]      header_o
);
    int falls = 0;
    initial data_o = 1'h0;
    initial header_o = 32'h0;
    // read header arrives msb first on rising edges
    always @(posedge sclk_i) begin
        if (!select_n_i && falls < 32) begin
            header_o <= {header_o[30:0], data_i};
        end
    end
    // word goes out after the header; a released line flips so that a
    // late sample cannot match by luck
    always @(negedge sclk_i or posedge select_n_i) begin
        if (select_n_i) begin
            falls <= 0;
            data_o <= ~data_o;
        end else begin
            falls <= falls + 1;
            if (falls >= 31 && falls < 63) begin
                data_o <= WORD[62-falls];
            end
        end
    end
endmodule // cps_flash_model

// File: bench/cps_top_tb_top.sv
`timescale 1ns/100ps
module cps_top_tb_top;
    import cps_pkg::*;
    localparam logic [31:0] F_WORD = 32'ha5c3_0f96;
    localparam logic [31:0] H_WORD = 32'h9234_8001;
    localparam logic [31:0] T_WORD = 32'h5a0f_c3e1;
    // test port path from reset through an instruction load to shift-DR
    localparam logic [12:0] TAP_TMS = 13'h0706;
    logic clk = 0, rst_n = 0, prog_n = 1, toe_n = 1;
    logic hclk = 0, hsel_n = 1, hdat = 0;
    logic tck = 0, tms = 0, tdi = 0;
    logic [MODE_W-1:0] mode = MODE_MASTER;
    logic ino, inoe, dno, dnoe, cko, ckoe, pao, paoe, pbo, pboe;
    logic fsel_n, hiz, tdo, tdoe, user, rej, fdat;
    logic [31:0] word, hdr, tq;
    int failures = 0, compares = 0, cycles = 0;
    // open-drain pins idle high through pull-ups
    wire lclk = ckoe ? cko : hclk;
    wire pad_a = paoe ? pao : hdat;
    wire pad_b = pboe ? pbo : fdat;
    always #12.5 clk = ~clk;
    cps_top u_cps_top (.SYS_CLK_I(clk), .RESETN_I(rst_n), .CFG_MODE_I(mode),
        .INIT_READY_N_I(~inoe), .INIT_READY_N_O(ino),
        .INIT_READY_N_OE_O(inoe), .PROGRAM_REQUEST_N_I(prog_n),
        .DONE_I(~dnoe), .DONE_O(dno), .DONE_OE_O(dnoe),
        .CONFIG_SERIAL_CLOCK_I(lclk), .CONFIG_SERIAL_CLOCK_O(cko),
        .CONFIG_SERIAL_CLOCK_OE_O(ckoe), .SERIAL_DATA_PAD_A_I(pad_a),
        .SERIAL_DATA_PAD_A_O(pao), .SERIAL_DATA_PAD_A_OE_O(paoe),
        .SERIAL_DATA_PAD_B_I(pad_b), .SERIAL_DATA_PAD_B_O(pbo),
        .SERIAL_DATA_PAD_B_OE_O(pboe), .FLASH_SELECT_N_O(fsel_n),
        .SLAVE_SELECT_IN_N_I(hsel_n), .IO_TRISTATE_CTRL_N_I(toe_n),
        .USER_IO_HIZ_O(hiz), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
        .TDO_O(tdo), .TDO_OE_O(tdoe), .CONFIG_WORD_O(word),
        .USER_MODE_O(user), .PORT_REJECT_O(rej));
    cps_flash_model #(.WORD(F_WORD)) u_cps_flash_model (.sclk_i(cko),
        .select_n_i(fsel_n), .data_i(pao), .data_o(fdat), .header_o(hdr));
    task automatic check(input string nm, input logic [31:0] e, g);
        compares++;
        if (e !== g) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_user();
        for (int i = 0; i < 4000 && user !== 1'h1; i++) @(posedge clk);
    endtask
    // host frame, link clock stands still outside it
    task automatic host_send(input logic [31:0] w);
        hsel_n <= 1'h0;
        for (int i = 31; i >= 0; i--) begin
            hdat <= w[i];
            #50 hclk = 1;
            #62.5 hclk = 0;
            #12.5;
        end
        hdat <= ~w[0];
        #100 hsel_n <= 1'h1;
    endtask
    // test clock phases span 8 system clocks so the pin filter keeps up
    task automatic tap_step(input logic ms, di);
        tms <= ms;
        tdi <= di;
        repeat (8) @(posedge clk);
        tck <= 1'h1;
        repeat (8) @(posedge clk);
        tck <= 1'h0;
        repeat (8) @(posedge clk);
    endtask
    // instruction load, capture, 32 shifts of w lsb first, then update
    task automatic tap_scan(input logic [31:0] w);
        for (int i = 0; i < 47; i++) begin
            tap_step(i < 13 ? TAP_TMS[i] : (i > 43),
                     i == 6 || (i > 12 && i < 45 && w[i-13]));
            if (i > 11 && i < 44)
                tq = {tdo, tq[31:1]};
            if (i == 43)
                check("tdo_oe", 1'h1, tdoe);
        end
    endtask
    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard well past three full loads
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        repeat (60) @(posedge clk);
        check("fsel_n", 1'h0, fsel_n);
        check("pad_a_oe", 1'h1, paoe);
        check("pad_b_oe", 1'h0, pboe);
        check("clk_oe", 1'h1, ckoe);
        check("init_o", 1'h0, ino);
        check("done_o", 1'h0, dno);
        wait_user();
        check("user", 1'h1, user);
        check("word", F_WORD, word);
        check("header", {FLASH_READ_CMD, FLASH_ADDR}, hdr);
        check("done_oe", 1'h0, dnoe);
        $display("test master load done");
        mode <= MODE_SLAVE;
        prog_n <= 1'h0;
        repeat (10) @(posedge clk);
        check("init_oe", 1'h1, inoe);
        check("done_oe", 1'h1, dnoe);
        prog_n <= 1'h1;
        repeat (60) @(posedge clk);
        check("reject", 1'h1, rej);
        check("init_oe", 1'h0, inoe);
        $display("test port lock done");
        rst_n <= 1'h0;
        @(posedge clk);
        rst_n <= 1'h1;
        repeat (60) @(posedge clk);
        check("reject", 1'h0, rej);
        host_send(H_WORD);
        check("pad_b", H_WORD[31], pbo);
        wait_user();
        check("word", H_WORD, word);
        check("user", 1'h1, user);
        $display("test slave load done");
        toe_n <= 1'h0;
        repeat (8) @(posedge clk);
        check("hiz", 1'h1, hiz);
        toe_n <= 1'h1;
        repeat (8) @(posedge clk);
        check("hiz", 1'h0, hiz);
        $display("test tristate done");
        tap_scan(32'h0);
        check("tdo", H_WORD, tq);
        check("tdo_oe", 1'h0, tdoe);
        $display("test tap capture done");
        mode <= MODE_TAP;
        rst_n <= 1'h0;
        @(posedge clk);
        rst_n <= 1'h1;
        repeat (60) @(posedge clk);
        tap_scan(T_WORD);
        check("tdo", 32'h0, tq);
        wait_user();
        check("word", T_WORD, word);
        check("user", 1'h1, user);
        $display("test tap load done");
        summarize();
    end
endmodule // cps_top_tb_top
